/* File: logic/epi_ext_irq.sv */
`timescale 1ns/100ps
module epi_ext_irq #(
	parameter int STARTUP_CYCLES = 1000
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire epi_pkg::epi_bus_req_type bus_req,
	output logic [7:0]                   bus_rdata,
	input  wire logic                    ext_irq_pin_a,
	input  wire logic                    ext_irq_pin_b,
	input  wire logic                    ext_irq_pin_c_edge_only,
	input  wire logic [15:0]             pin_change_inputs,
	input  wire logic                    global_irq_en,
	input  wire logic [4:0]              irq_ack,
	input  wire logic                    sleep_enter,
	input  wire logic                    sleep_idle,
	output logic [4:0]                   irq_req,
	output logic                         core_awake
);

	localparam int SW = $clog2(STARTUP_CYCLES + 1);
	localparam int WW = $clog2(epi_pkg::WDT_CYCLES + 1);
	localparam logic [SW-1:0] START_LAST = SW'(STARTUP_CYCLES - 1);
	localparam logic [WW-1:0] WDT_LAST   = WW'(epi_pkg::WDT_CYCLES - 1);

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	// Edge compare for a two-bit sense field; level mode gives no edge.
	// Sense code decode
	function automatic logic sense_hit(input logic [1:0] mode, input logic cur, input logic prv);
		logic hit;
		hit = 1'b0;
		unique case (mode)
			epi_pkg::SENSE_LOW:    hit = 1'b0;
			epi_pkg::SENSE_CHANGE: hit = cur ^ prv;
			epi_pkg::SENSE_FALL:   hit = prv & ~cur;
			epi_pkg::SENSE_RISE:   hit = cur & ~prv;
		endcase
		return hit;
	endfunction

	// Register byte decode for the write strobes; the read mux decodes the address in its own case.
	function automatic logic hit_reg(input logic [2:0] a, input logic [2:0] off);
		return a == off;
	endfunction

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [7:0]           ctrl_r;
	logic [7:0]           ext_r;
	logic [4:0]           en_r;
	logic [4:0]           flag_r;
	logic [4:0]           flag_nxt;
	logic [7:0]           mask_l_r;
	logic [7:0]           mask_u_r;
	logic [7:0]           rdata_r;
	logic [4:0]           irq_r;
	logic [4:0]           irq_nxt;
	logic                 awake_r;
	logic                 idle_r;
	logic [1:0]           low_seen_r;
	logic [SW-1:0]        start_cnt_r;
	logic [WW-1:0]        wdt_cnt_r;
	epi_pkg::epi_state_type state_r;
	epi_pkg::epi_state_type state_nxt;

	// ---------------------------------------------------------------
	// Pin sampling
	// ---------------------------------------------------------------
	logic [18:0] pin_cur;
	logic [18:0] pin_prv;

	epi_sync #(
		.W(19)
	) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in ({pin_change_inputs, ext_irq_pin_c_edge_only, ext_irq_pin_b, ext_irq_pin_a}),
		.sync_out (pin_cur),
		.sync_prev(pin_prv)
	);

	// ---------------------------------------------------------------
	// Field and decode wires
	// ---------------------------------------------------------------
	wire [1:0]  sense_a   = ctrl_r[epi_pkg::SENSE_A_LSB +: 2];
	wire [1:0]  sense_b   = ctrl_r[epi_pkg::SENSE_B_LSB +: 2];
	wire        pol_c     = ext_r[epi_pkg::POL_C_BIT];
	wire        lvl_a     = sense_a == epi_pkg::SENSE_LOW;
	wire        lvl_b     = sense_b == epi_pkg::SENSE_LOW;
	wire        in_run    = state_r == epi_pkg::ST_RUN;
	wire        in_sleep  = state_r == epi_pkg::ST_SLEEP;
	wire        in_start  = state_r == epi_pkg::ST_START;
	wire        wr_en     = bus_req.we;
	wire [7:0]  wd        = bus_req.wdata;
	wire [4:0]  w1c       = (wr_en && hit_reg(bus_req.addr, epi_pkg::REG_FLAGS)) ?
	                        wd[epi_pkg::IRQ_LSB +: 5] : 5'h00;
	wire [15:0] pc_tgl    = pin_cur[18:3] ^ pin_prv[18:3];

	wire        io_run    = in_run | (in_sleep & idle_r);

	// ---------------------------------------------------------------
	// Event detection
	// ---------------------------------------------------------------
	// Clocked edges gated
	wire edge_a = io_run & sense_hit(sense_a, pin_cur[0], pin_prv[0]);
	wire edge_b = io_run & sense_hit(sense_b, pin_cur[1], pin_prv[1]);
	wire edge_c = pol_c ? (pin_cur[2] & ~pin_prv[2]) : (pin_prv[2] & ~pin_cur[2]);
	wire pc_u   = |(pc_tgl[15:8] & mask_u_r);
	wire pc_l   = |(pc_tgl[7:0] & mask_l_r);

	wire [4:0] set_vec = {edge_b, edge_a, edge_c, pc_u, pc_l};
	wire [4:0] lvl_mode = {lvl_b, lvl_a, 3'h0};

	// Level requests only in run state, so a level lost during start-up is dropped.
	// Level held request
	wire [4:0] lvl_now = {lvl_b & ~pin_cur[1], lvl_a & ~pin_cur[0], 3'h0} & {5{in_run}};

	// ---------------------------------------------------------------
	// Flags and requests
	// ---------------------------------------------------------------
	// Set wins, level clears
	assign flag_nxt = (set_vec | (flag_r & ~(irq_ack | w1c))) & ~lvl_mode;

	assign irq_nxt  = (flag_r | lvl_now) & en_r & {5{global_irq_en}};

	// ---------------------------------------------------------------
	// Sleep and wake sequencing
	// ---------------------------------------------------------------
	wire       wdt_tick  = wdt_cnt_r == WDT_LAST;
	wire [1:0] low_now   = {lvl_b & en_r[epi_pkg::IRQ_B] & ~pin_cur[1], lvl_a & en_r[epi_pkg::IRQ_A] & ~pin_cur[0]};
	wire       lvl_wake  = wdt_tick & |(low_seen_r & low_now);
	wire       wake_evt  = |(set_vec & en_r) | lvl_wake;

	// Next state of the power sequencer.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			epi_pkg::ST_RUN:   if (sleep_enter) state_nxt = epi_pkg::ST_SLEEP;
			epi_pkg::ST_SLEEP: if (wake_evt) state_nxt = epi_pkg::ST_START;
			epi_pkg::ST_START: if (start_cnt_r == START_LAST) state_nxt = epi_pkg::ST_RUN;
			default:           state_nxt = epi_pkg::ST_RUN;
		endcase
	end

	// State, sleep kind and the start-up counter.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r     <= epi_pkg::ST_RUN;
			idle_r      <= 1'b0;
			start_cnt_r <= '0;
		end else begin
			state_r     <= state_nxt;
			idle_r      <= (in_run && sleep_enter) ? sleep_idle : idle_r;
			start_cnt_r <= in_start ? start_cnt_r + 1'b1 : '0;
		end
	end

	// Watchdog tick divider and low-level history; the divider runs free.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdt_cnt_r  <= '0;
			low_seen_r <= 2'h0;
		end else begin
			wdt_cnt_r  <= wdt_tick ? '0 : wdt_cnt_r + 1'b1;
			low_seen_r <= wdt_tick ? (low_now & {2{in_sleep}}) : low_seen_r;
		end
	end

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	wire wr_ctrl = wr_en && hit_reg(bus_req.addr, epi_pkg::REG_CTRL);
	wire wr_ext  = wr_en && hit_reg(bus_req.addr, epi_pkg::REG_EXT);
	wire wr_en_r = wr_en && hit_reg(bus_req.addr, epi_pkg::REG_ENABLE);
	wire wr_ml   = wr_en && hit_reg(bus_req.addr, epi_pkg::REG_MASK_L);
	wire wr_mu   = wr_en && hit_reg(bus_req.addr, epi_pkg::REG_MASK_U);

	// Software-written configuration.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r   <= epi_pkg::RST_BYTE;
			ext_r    <= epi_pkg::RST_BYTE;
			en_r     <= 5'h00;
			mask_l_r <= epi_pkg::RST_BYTE;
			mask_u_r <= epi_pkg::RST_BYTE;
		end else begin
			ctrl_r   <= wr_ctrl ? wd : ctrl_r;
			ext_r    <= wr_ext ? wd : ext_r;
			en_r     <= wr_en_r ? wd[epi_pkg::IRQ_LSB +: 5] : en_r;
			mask_l_r <= wr_ml ? wd : mask_l_r;
			mask_u_r <= wr_mu ? wd : mask_u_r;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;

	// Unmapped offsets read as zero, as do bits 2..0 of the enable and flag registers.
	always_comb begin
		rd_mux = 8'h00;
		unique case (bus_req.addr)
			epi_pkg::REG_CTRL:   rd_mux = ctrl_r;
			epi_pkg::REG_EXT:    rd_mux = ext_r;
			epi_pkg::REG_ENABLE: rd_mux = {en_r, 3'h0};
			epi_pkg::REG_FLAGS:  rd_mux = {flag_r, 3'h0};
			epi_pkg::REG_MASK_L: rd_mux = mask_l_r;
			epi_pkg::REG_MASK_U: rd_mux = mask_u_r;
			default:             rd_mux = 8'h00;
		endcase
	end

	// Flags, requests, read data and wake status; all outputs are these flops.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_r  <= 5'h00;
			irq_r   <= 5'h00;
			rdata_r <= 8'h00;
			awake_r <= 1'b1;
		end else begin
			flag_r  <= flag_nxt;
			irq_r   <= irq_nxt;
			rdata_r <= bus_req.re ? rd_mux : 8'h00;
			awake_r <= state_nxt == epi_pkg::ST_RUN;
		end
	end

	assign bus_rdata  = rdata_r;
	assign irq_req    = irq_r;
	assign core_awake = awake_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	lvl_req_b_a: assert property (in_run && lvl_b && !pin_cur[1] && en_r[epi_pkg::IRQ_B] && global_irq_en
		|=> irq_req[epi_pkg::IRQ_B])
		else $error("level request on pin b missing");

	glob_gate_a: assert property (!global_irq_en |=> irq_req == 5'h00)
		else $error("request raised with global enable off");

	lvl_flag_clr_a: assert property (lvl_a |=> !flag_r[epi_pkg::IRQ_A])
		else $error("pin a flag set in level mode");

	set_wins_a: assert property (set_vec[epi_pkg::IRQ_C] && irq_ack[epi_pkg::IRQ_C] |=> flag_r[epi_pkg::IRQ_C])
		else $error("pin c event lost to clear");

	set_wins_pc_a: assert property (set_vec[epi_pkg::IRQ_PCL] && irq_ack[epi_pkg::IRQ_PCL]
		|=> flag_r[epi_pkg::IRQ_PCL])
		else $error("pin-change event lost to clear");

	mask_lower_a: assert property ((pc_tgl[7:0] & mask_l_r) == 8'h00 && !flag_r[epi_pkg::IRQ_PCL]
		|=> !flag_r[epi_pkg::IRQ_PCL])
		else $error("masked pin change set the lower flag");

	c_edge_only_a: assert property (pin_cur[2] == pin_prv[2] && !flag_r[epi_pkg::IRQ_C]
		|=> !flag_r[epi_pkg::IRQ_C])
		else $error("pin c flag set without an edge");

	fall_code_a: assert property (in_run && sense_b == epi_pkg::SENSE_FALL && pin_prv[1] && !pin_cur[1]
		|=> flag_r[epi_pkg::IRQ_B])
		else $error("falling edge on pin b not flagged");

	edge_stop_a: assert property (in_sleep && !idle_r && !flag_r[epi_pkg::IRQ_A]
		|=> !flag_r[epi_pkg::IRQ_A])
		else $error("pin a edge seen with I/O clock stopped");

	pc_upper_a: assert property ((pc_tgl[15:8] & mask_u_r) != 8'h00 |=> ##1 irq_req[epi_pkg::IRQ_PCU] ||
		!(en_r[epi_pkg::IRQ_PCU] && global_irq_en) || $past(irq_ack[epi_pkg::IRQ_PCU]) || $past(w1c[epi_pkg::IRQ_PCU]))
		else $error("upper pin-change request missing");

	c_wake_a: assert property (in_sleep && edge_c && en_r[epi_pkg::IRQ_C] |=> in_start)
		else $error("pin c edge did not wake");

	start_len_a: assert property (in_start && start_cnt_r != START_LAST |=> in_start && !core_awake)
		else $error("start-up ended early");

	lvl_wake_a: assert property (in_sleep && !(|(set_vec & en_r)) && low_seen_r == 2'h0
		|=> !in_start)
		else $error("wake without double sample");

	lvl_drop_a: assert property (in_start ##1 in_run && pin_cur[1] && !flag_r[epi_pkg::IRQ_B]
		|=> !irq_req[epi_pkg::IRQ_B])
		else $error("level request after level vanished");

	pc_lower_c: cover property (pc_l ##2 irq_req[epi_pkg::IRQ_PCL]);
	lvl_wake_c: cover property (in_sleep ##1 lvl_wake ##1 in_start);
	b_edge_c:   cover property (edge_b ##1 flag_r[epi_pkg::IRQ_B] ##1 irq_req[epi_pkg::IRQ_B]);
	rd_flag_c:  cover property (bus_req.re && hit_reg(bus_req.addr, epi_pkg::REG_FLAGS) ##1 bus_rdata != 8'h00);

endmodule

/* File: logic/epi_pkg.sv */
package epi_pkg;

	// ---------------------------------------------------------------
	// Register map and fields
	// ---------------------------------------------------------------
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_EXT    = 3'h1;
	localparam logic [2:0] REG_ENABLE = 3'h2;
	localparam logic [2:0] REG_FLAGS  = 3'h3;
	localparam logic [2:0] REG_MASK_L = 3'h4;
	localparam logic [2:0] REG_MASK_U = 3'h5;
	localparam logic [7:0] RST_BYTE   = 8'h00;

	localparam int SENSE_B_LSB = 2;
	localparam int SENSE_A_LSB = 0;
	localparam int POL_C_BIT   = 0;
	localparam int IRQ_LSB     = 3;

	// Source index inside five-bit vectors, matching bits 7..3.
	localparam int IRQ_B   = 4;
	localparam int IRQ_A   = 3;
	localparam int IRQ_C   = 2;
	localparam int IRQ_PCU = 1;
	localparam int IRQ_PCL = 0;
	localparam int NUM_IRQ = 5;

	// ---------------------------------------------------------------
	// Sense field encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] SENSE_LOW    = 2'h0;
	localparam logic [1:0] SENSE_CHANGE = 2'h1;
	localparam logic [1:0] SENSE_FALL   = 2'h2;
	localparam logic [1:0] SENSE_RISE   = 2'h3;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int WDT_PERIOD_NS = 1000;
	localparam int WDT_CYCLES    = (WDT_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : WDT_PERIOD_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} epi_bus_req_type;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_START = 3'b100
	} epi_state_type;

endpackage

/* File: logic/epi_sync.sv */
`timescale 1ns/100ps
module epi_sync #(
	parameter int W = 19
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out,
	output logic      [W-1:0] sync_prev
);

	// ---------------------------------------------------------------
	// Two-stage synchroniser plus one history stage
	// ---------------------------------------------------------------
	logic [W-1:0] meta_r;
	logic [W-1:0] stab_r;
	logic [W-1:0] prev_r;

	// Only stab_r reads meta_r, so a metastable first stage never reaches logic.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '1;
			stab_r <= '1;
			prev_r <= '1;
		end else begin
			meta_r <= async_in;
			stab_r <= meta_r;
			prev_r <= stab_r;
		end
	end

	assign sync_out  = stab_r;
	assign sync_prev = prev_r;

endmodule

/* File: tb/epi_pin_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// External sources on the interrupt pins
// ----------------------------------------
module epi_pin_model (
	input  wire logic        clk,
	output logic             pin_a,
	output logic             pin_b,
	output logic             pin_c,
	output logic [15:0]      pcin
);
	// Pins rest high, as the board pull-ups hold them when nobody drives.
	initial begin
		{pin_c, pin_b, pin_a} = 3'h7;
		pcin = 16'hFFFF;
	end

	// Drives {c,b,a} just after an edge and holds them until the next call.
	// low held long
	task automatic drive(input logic [2:0] v);
		@(posedge clk);
		{pin_c, pin_b, pin_a} <= v;
	endtask

	// Flips one pin-change input; the new level is held, never a short glitch.
	task automatic toggle(input int idx);
		@(posedge clk);
		pcin[idx] <= ~pcin[idx];
	endtask

	// Sets the whole pin-change vector at once; held until the next call.
	task automatic set_pc(input logic [15:0] v);
		@(posedge clk);
		pcin <= v;
	endtask
endmodule

/* File: tb/tb_external_pin_interrupt_detector.sv */
`timescale 1ns/100ps
module tb_external_pin_interrupt_detector;
	logic                     clk = 1'b0;
	logic                     rst_b = 1'b0;
	epi_pkg::epi_bus_req_type bus_req = '0;
	logic [7:0]               bus_rdata;
	logic                     pin_a, pin_b, pin_c;
	logic [15:0]              pcin;
	logic                     global_irq_en = 1'b1;
	logic [4:0]               irq_ack = 5'h00;
	logic                     sleep_enter = 1'b0;
	logic                     sleep_idle = 1'b0;
	logic [4:0]               irq_req;
	logic                     core_awake;
	logic                     rd_seen = 1'b0;
	logic                     look_req = 1'b0;
	logic [7:0]               exp_q[$];
	logic [7:0]               exp_v, got, m;
	int                       n_errors = 0;
	int                       cmp_count = 0;
	int                       seed = 63;
	int                       idx;

	// 50 MHz clock.
	always #10 clk = ~clk;

	epi_ext_irq #(.STARTUP_CYCLES(8)) u_epi_ext_irq (
		.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .ext_irq_pin_c_edge_only(pin_c),
		.pin_change_inputs(pcin), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
		.sleep_enter(sleep_enter), .sleep_idle(sleep_idle), .irq_req(irq_req), .core_awake(core_awake)
	);

	epi_pin_model u_epi_pin_model (
		.clk(clk), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c), .pcin(pcin)
	);

	// ----------------------------------------
	// Bus and observation tasks
	// ----------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus_req <= '0;
	endtask

	// Notes {awake, requests} as one byte, looked at once by the monitor.
	task automatic look(input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		look_req <= 1'b1;
		@(posedge clk);
		look_req <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic clr();
		wr(epi_pkg::REG_FLAGS, 8'hF8);
	endtask

	task automatic sleep(input logic i);
		@(posedge clk);
		sleep_enter <= 1'b1;
		sleep_idle <= i;
		@(posedge clk);
		sleep_enter <= 1'b0;
		idle(2);
	endtask

	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Wake-up has a bounded wait; running out of it ends the run.
	task automatic wait_awake(input int n);
		int i;
		i = 0;
		while (core_awake !== 1'b1 && i < n) begin
			@(posedge clk);
			i++;
		end
		cmp_count++;
		if (core_awake !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: core stayed asleep", $time);
			report_and_stop();
		end
	endtask

	// ----------------------------------------
	// Monitor: read data stands only in the cycle after the strobe
	// ----------------------------------------
	always @(posedge clk) rd_seen <= bus_req.re;

	// Compares each result with the oldest note at mid-cycle, where outputs are settled.
	always @(negedge clk) begin
		if (rd_seen || look_req) begin
			cmp_count++;
			exp_v = exp_q.pop_front();
			got = rd_seen ? bus_rdata : {2'h0, core_awake, irq_req};
			if (got !== exp_v) begin
				n_errors++;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp_v);
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], 8'h00);
		end
		m = $random(seed);
		wr(epi_pkg::REG_MASK_U, m);
		rd(epi_pkg::REG_MASK_U, m);
		wr(epi_pkg::REG_ENABLE, 8'hC0);
		// Each sense code on pins a and b at once; flags sit at bits 7 and 6.
		for (int c = 0; c < 4; c++) begin
			wr(epi_pkg::REG_CTRL, {4'h0, c[1:0], c[1:0]});
			clr();
			u_epi_pin_model.drive(3'b100);
			idle(4);
			rd(epi_pkg::REG_FLAGS, (c == 1 || c == 2) ? 8'hC0 : 8'h00);
			if (c == 0) begin
				look(8'h38);
				@(posedge clk) global_irq_en <= 1'b0;
				idle(1);
				look(8'h20);
				@(posedge clk) global_irq_en <= 1'b1;
			end
			clr();
			u_epi_pin_model.drive(3'b111);
			idle(4);
			rd(epi_pkg::REG_FLAGS, (c == 1 || c == 3) ? 8'hC0 : 8'h00);
		end
		// Pin c is edge only, polarity chosen by bit 0.
		wr(epi_pkg::REG_ENABLE, 8'h20);
		for (int p = 0; p < 2; p++) begin
			wr(epi_pkg::REG_EXT, {7'h00, p[0]});
			clr();
			u_epi_pin_model.drive(3'b011);
			idle(4);
			rd(epi_pkg::REG_FLAGS, p ? 8'h00 : 8'h20);
			if (p == 0) look(8'h24);
			clr();
			u_epi_pin_model.drive(3'b111);
			idle(4);
			rd(epi_pkg::REG_FLAGS, p ? 8'h20 : 8'h00);
		end
		// Upper pin-change group: one unmasked and one masked input.
		wr(epi_pkg::REG_MASK_U, 8'h02);
		wr(epi_pkg::REG_ENABLE, 8'h10);
		clr();
		u_epi_pin_model.toggle(9);
		idle(4);
		rd(epi_pkg::REG_FLAGS, 8'h10);
		look(8'h22);
		@(posedge clk) irq_ack <= 5'h02;
		@(posedge clk) irq_ack <= 5'h00;
		idle(1);
		rd(epi_pkg::REG_FLAGS, 8'h00);
		u_epi_pin_model.toggle(10);
		idle(4);
		rd(epi_pkg::REG_FLAGS, 8'h00);
		// Lower group: a random unmasked input, toggled both ways.
		idx = $unsigned($random(seed)) % 8;
		m = $random(seed);
		m[idx] = 1'b1;
		wr(epi_pkg::REG_MASK_L, m);
		wr(epi_pkg::REG_ENABLE, 8'h08);
		for (int k = 0; k < 2; k++) begin
			clr();
			u_epi_pin_model.toggle(idx);
			idle(4);
			rd(epi_pkg::REG_FLAGS, 8'h08);
		end
		// All inputs masked: a random new value on the pin-change inputs sets nothing.
		wr(epi_pkg::REG_MASK_L, 8'h00);
		wr(epi_pkg::REG_MASK_U, 8'h00);
		clr();
		u_epi_pin_model.set_pc(16'($random(seed)));
		idle(4);
		rd(epi_pkg::REG_FLAGS, 8'h00);
		// All unmasked; an acknowledge in the cycle of the event loses to it.
		wr(epi_pkg::REG_MASK_L, 8'hFF);
		wr(epi_pkg::REG_MASK_U, 8'hFF);
		wr(epi_pkg::REG_ENABLE, 8'h18);
		clr();
		u_epi_pin_model.set_pc(~pcin);
		@(posedge clk);
		@(posedge clk) irq_ack <= 5'h1F;
		@(posedge clk) irq_ack <= 5'h00;
		rd(epi_pkg::REG_FLAGS, 8'h18);
		look(8'h23);
		@(posedge clk) irq_ack <= 5'h1F;
		@(posedge clk) irq_ack <= 5'h00;
		idle(1);
		rd(epi_pkg::REG_FLAGS, 8'h00);
		// Deep sleep ignores clocked edges on pin a; a pin change still wakes.
		wr(epi_pkg::REG_CTRL, 8'h02);
		wr(epi_pkg::REG_ENABLE, 8'h48);
		clr();
		sleep(1'b0);
		u_epi_pin_model.drive(3'b110);
		idle(20);
		look(8'h00);
		u_epi_pin_model.drive(3'b111);
		u_epi_pin_model.toggle(idx);
		wait_awake(100);
		// Idle sleep keeps the clock, so a falling edge on pin a wakes.
		sleep(1'b1);
		u_epi_pin_model.drive(3'b110);
		wait_awake(100);
		u_epi_pin_model.drive(3'b111);
		// Low level held through start-up wakes and then requests.
		wr(epi_pkg::REG_CTRL, 8'h00);
		clr();
		sleep(1'b0);
		u_epi_pin_model.drive(3'b110);
		wait_awake(400);
		idle(3);
		look(8'h28);
		u_epi_pin_model.drive(3'b111);
		// Deep sleep: pin c, set for rising edges, ignores a fall and wakes on a rise.
		wr(epi_pkg::REG_ENABLE, 8'h20);
		clr();
		sleep(1'b0);
		u_epi_pin_model.drive(3'b011);
		idle(4);
		look(8'h00);
		u_epi_pin_model.drive(3'b111);
		wait_awake(100);
		idle(4);
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("unexpected at %0t: results missing", $time);
		end
		report_and_stop();
	end
endmodule
